// [hw/sac_conv_ctrl.v]
// Conversion control logic of an 8-bit successive-approximation converter.
// Assumes one system clock; every pin input is asynchronous, and all but RST_IN are synchronised here.
`timescale 1ns/1ns
`default_nettype none
`include "sac_map.vh"

module sac_conv_ctrl (
  // System clock and reset.
  input wire CLK_IN,
  input wire RST_IN,
  // Host strobes.
  input wire START_PULSE_N_IN,
  input wire READ_EN_IN,
  // Converter clock and comparator decision.
  input wire CONV_CLK_IN,
  input wire COMP_HIGH_IN,
  // Status and result.
  output wire BUSY_N_OUT,
  output wire [`SAC_BITS-1:0] TRIAL_CODE_OUT,
  output wire [`SAC_BITS-1:0] DATA_OUT,
  output wire DATA_OE_OUT
);

  localparam ST_DONE = `SAC_ST_DONE;
  localparam ST_HOLD = `SAC_ST_HOLD;
  localparam ST_CONV = `SAC_ST_CONV;

  // Helper functions for the decision, the edge count and the pin filter.

  // Moves the trial one place down.
  function [`SAC_BITS-1:0] lower_bit;
    input [`SAC_BITS-1:0] bit_mask;
    begin
      lower_bit = bit_mask >> `SAC_SHIFT;
    end
  endfunction

  // Keeps or clears the bit under trial and raises the next lower one.
  function [`SAC_BITS-1:0] settle_bit;
    input [`SAC_BITS-1:0] code;
    input [`SAC_BITS-1:0] bit_mask;
    input comp;
    begin
      settle_bit = (code & ~(bit_mask & {`SAC_BITS{comp}})) | lower_bit(bit_mask);
    end
  endfunction

  // Takes a pin change only once stages two and three agree.
  function [`SAC_PINS-1:0] settle_pins;
    input [`SAC_PINS-1:0] held, stage2, stage3;
    begin
      settle_pins = (stage2 & stage3) | (held & (stage2 | stage3));
    end
  endfunction

  // Counts one more falling converter-clock edge.
  function [`SAC_CNT_W-1:0] count_up;
    input [`SAC_CNT_W-1:0] count;
    begin
      count_up = count + `SAC_CNT_STEP;
    end
  endfunction

  reg [`SAC_PINS-1:0] pin_s1;
  reg [`SAC_PINS-1:0] pin_s2;
  reg [`SAC_PINS-1:0] pin_s3;
  reg [`SAC_PINS-1:0] pin_filt;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [`SAC_BITS-1:0] sar;
  reg [`SAC_BITS-1:0] next_sar;
  reg [`SAC_BITS-1:0] trial;
  reg [`SAC_BITS-1:0] next_trial;
  reg busy_n;
  reg next_busy_n;
  reg read_en;
  wire start_low;
  wire clk_fall;
  wire comp_high;
  reg [`SAC_CNT_W-1:0] edge_count;
  reg [`SAC_CNT_W-1:0] next_edge_count;
  wire conv_done;

  // Three-stage synchronisers; a change is taken once stages two and three agree.
  always @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      pin_s1 <= `SAC_PINS_IDLE;
    end else begin
      pin_s1 <= {READ_EN_IN, COMP_HIGH_IN, CONV_CLK_IN, START_PULSE_N_IN};
    end
  end

  always @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      pin_s2 <= `SAC_PINS_IDLE;
    end else begin
      pin_s2 <= pin_s1;
    end
  end

  always @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      pin_s3 <= `SAC_PINS_IDLE;
    end else begin
      pin_s3 <= pin_s2;
    end
  end

  always @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      pin_filt <= `SAC_PINS_IDLE;
    end else begin
      pin_filt <= settle_pins(pin_filt, pin_s2, pin_s3);
    end
  end

  assign start_low = ~pin_filt[`SAC_PIN_START];
  assign clk_fall = pin_filt[`SAC_PIN_CLK] & ~pin_s2[`SAC_PIN_CLK] & ~pin_s3[`SAC_PIN_CLK];
  assign comp_high = pin_filt[`SAC_PIN_COMP];
  assign conv_done = (count_up(edge_count) == `SAC_LAST_EDGE);

  // Next-state logic of the approximation register.
  always @* begin
    next_state = state;
    next_sar = sar;
    next_trial = trial;
    next_busy_n = busy_n;
    next_edge_count = edge_count;
    if (start_low) begin
      next_state = ST_HOLD;
      next_sar = `SAC_TOP_BIT;
      next_trial = `SAC_TOP_BIT;
      next_busy_n = 1'b0;
      next_edge_count = `SAC_CNT_ZERO;
    end else begin
      case (state)
        ST_HOLD: begin
          next_state = ST_CONV;
        end
        ST_CONV: begin
          if (clk_fall) begin
            next_edge_count = count_up(edge_count);
            if (conv_done) begin
              next_state = ST_DONE;
              next_busy_n = 1'b1;
            end else begin
              next_sar = settle_bit(sar, trial, comp_high);
              next_trial = lower_bit(trial);
            end
          end
        end
        ST_DONE: begin
          next_state = ST_DONE;
        end
        default: begin
          next_state = ST_DONE;
        end
      endcase
    end
  end

  // Control registers: state, busy flag and edge count.
  always @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state <= ST_DONE;
      busy_n <= 1'b1;
      edge_count <= `SAC_CNT_ZERO;
    end else begin
      state <= next_state;
      busy_n <= next_busy_n;
      edge_count <= next_edge_count;
    end
  end

  // Data registers: approximation, trial bit and output enable.
  always @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sar <= `SAC_ZERO;
      trial <= `SAC_ZERO;
      read_en <= 1'b0;
    end else begin
      sar <= next_sar;
      trial <= next_trial;
      read_en <= pin_filt[`SAC_PIN_READ];
    end
  end

  assign BUSY_N_OUT = busy_n;
  assign TRIAL_CODE_OUT = sar;
  assign DATA_OUT = sar;
  assign DATA_OE_OUT = read_en;

endmodule

`default_nettype wire

// [hw/sac_map.vh]
// Constants for the successive-approximation conversion control block.
// Assumes inclusion by bare name from files under hw/.
`ifndef SAC_MAP_VH
`define SAC_MAP_VH

// Result width, start code and reset value.
`define SAC_BITS 8
`define SAC_TOP_BIT 8'h80
`define SAC_ZERO 8'h00

// Positions of the pin inputs inside the synchroniser vector.
`define SAC_PIN_START 0
`define SAC_PIN_CLK 1
`define SAC_PIN_COMP 2
`define SAC_PIN_READ 3
`define SAC_PINS 4
`define SAC_PINS_IDLE 4'h3

// Falling converter-clock edge count and trial shift step.
`define SAC_CNT_W 4
`define SAC_CNT_ZERO 4'h0
`define SAC_CNT_STEP 4'h1
`define SAC_LAST_EDGE 4'h9
`define SAC_SHIFT 1

// Control states, one-hot.
`define SAC_ST_DONE 3'h1
`define SAC_ST_HOLD 3'h2
`define SAC_ST_CONV 3'h4

`endif

// [tb/sac_cmp.sv]
// Far side model: comparator and the host's address-decoded start and read strobes.
// Assumes the level is held steady through a conversion.
`timescale 1ns/1ns
`default_nettype none
module sac_cmp (
  input wire logic [7:0] trial_in, level_in,
  input wire logic hit_in, wr_in, rd_in,
  output logic high_out, start_n_out, read_out
);
  assign high_out = trial_in > level_in;
  assign start_n_out = !(hit_in && wr_in);
  assign read_out = hit_in && rd_in;
endmodule
`default_nettype wire

// [tb/sac_props.sv]
// Port checker of the conversion control block.
// Assumes it is bound to the block's top module.
`timescale 1ns/1ns
`default_nettype none
module sac_props (
  input wire logic CLK_IN, RST_IN, START_PULSE_N_IN, READ_EN_IN, CONV_CLK_IN, COMP_HIGH_IN,
  input wire logic BUSY_N_OUT, DATA_OE_OUT,
  input wire logic [7:0] TRIAL_CODE_OUT, DATA_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  property p_hold; !START_PULSE_N_IN[*8] |-> !BUSY_N_OUT && TRIAL_CODE_OUT == 8'h80; endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_top; $fell(BUSY_N_OUT) |-> TRIAL_CODE_OUT == 8'h80; endproperty
  a_top: assert property (p_top) else $error("top");
  property p_low; $fell(BUSY_N_OUT) |-> (!BUSY_N_OUT)[*8]; endproperty
  a_low: assert property (p_low) else $error("low");
  property p_keep; BUSY_N_OUT && $past(BUSY_N_OUT) |-> $stable(DATA_OUT); endproperty
  a_keep: assert property (p_keep) else $error("keep");
  property p_still; (CONV_CLK_IN && START_PULSE_N_IN)[*8] |-> $stable(TRIAL_CODE_OUT); endproperty
  a_still: assert property (p_still) else $error("still");
  property p_rise; $rose(BUSY_N_OUT) |-> $past(START_PULSE_N_IN, 8); endproperty
  a_rise: assert property (p_rise) else $error("rise");
  property p_on; $rose(READ_EN_IN) |-> ##[3:6] DATA_OE_OUT; endproperty
  a_on: assert property (p_on) else $error("on");
  property p_off; $fell(READ_EN_IN) |-> ##[3:6] !DATA_OE_OUT; endproperty
  a_off: assert property (p_off) else $error("off");
endmodule
bind sac_conv_ctrl sac_props CHK (.*);
`default_nettype wire

// [tb/tb.sv]
// Bench: host-clocked conversions read after a fixed wait, one with busy tied to read,
// and self-synchronised conversions read on the busy interrupt.
// Assumes the far side model and the bound checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk = 0, rst = 1, hit = 0, wr = 0, rdq = 0, tie = 0, cck = 1;
  logic [7:0] lvl = 8'h00;
  wire st_n, rdx, rd_pin, cmp, bsy, oe;
  wire [7:0] trl, dat;
  int err_total = 0, n_compared = 0;
  assign rd_pin = tie ? bsy : rdx;
  sac_conv_ctrl DUT (.CLK_IN(clk), .RST_IN(rst), .START_PULSE_N_IN(st_n), .READ_EN_IN(rd_pin),
    .CONV_CLK_IN(cck), .COMP_HIGH_IN(cmp), .BUSY_N_OUT(bsy), .TRIAL_CODE_OUT(trl),
    .DATA_OUT(dat), .DATA_OE_OUT(oe));
  sac_cmp CMP (.trial_in(trl), .level_in(lvl), .hit_in(hit), .wr_in(wr), .rd_in(rdq),
    .high_out(cmp), .start_n_out(st_n), .read_out(rdx));
  initial forever #5 clk = ~clk;
  task automatic cyc(input int n); repeat (n) @(negedge clk); endtask
  task automatic chk(input string s, input logic [8:0] v, e);
    n_compared++;
    if (v !== e) err_total++;
    if (v !== e) $display("Error %s expected %h seen %h", s, e, v);
  endtask
  task automatic conv(input logic [7:0] v, input logic t);
    lvl = v;
    tie = t;
    hit = 1;
    wr = 1;
    cyc(100);
    chk("start", {bsy, trl}, 9'h080);
    hit = 0;
    wr = 0;
    for (int i = 1; i < 10; i++) begin
      cck = 1;
      cyc(60);
      cck = 0;
      cyc(60);
      chk("busy", {bsy, oe, 7'h00}, {i == 9, t && i == 9, 7'h00});
    end
    hit = 1;
    rdq = 1;
    cyc(8);
    chk("read", {oe, dat}, {1'b1, v});
    hit = 0;
    rdq = 0;
    tie = 0;
  endtask
  task automatic conv_self(input logic [7:0] v);
    int n;
    n = 0;
    lvl = v;
    cck = 1;
    hit = 1;
    wr = 1;
    cyc(40);
    hit = 0;
    wr = 0;
    chk("armed", {bsy, trl}, 9'h080);
    cyc(120);
    for (int k = 0; k < 20 && !bsy; k++) begin
      cck = 0;
      n++;
      cyc(60);
      cck = 1;
      cyc(60);
    end
    chk("falls", n[8:0], 9'h009);
    hit = 1;
    rdq = 1;
    cyc(8);
    chk("irq read", {oe, dat}, {1'b1, v});
    hit = 0;
    rdq = 0;
  endtask
  task automatic conclude;
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    cyc(12);
    rst = 0;
    conv(8'h66, 1'b0);
    conv(8'h00, 1'b1);
    conv(8'hFF, 1'b0);
    conv_self(8'hA5);
    conv_self(8'h01);
    conclude();
  end
endmodule
`default_nettype wire
